// File: hw/adst_top.sv
`timescale 1ns/1ps
module adst_top
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Serial port pins
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  output logic dout_rdy,
  output logic dout_oe,
  // Conversion engine results
  input wire logic res_wr,
  input wire logic [23:0] res_value,
  input wire logic res_over,
  input wire logic res_under,
  input wire logic [3:0] res_chan,
  input wire logic cal_mode,
  input wire logic cal_wr,
  // Interface mode and checksum logic
  input wire logic append_status,
  input wire logic integ_en,
  input wire logic [7:0] reg_sum,
  input wire logic wr_crc_fail,
  // Observation
  output logic [7:0] status_out
);
  typedef struct packed
  {
    adst_pkg::adst_phase_e phase;
    logic sclk_d;
    logic [5:0] bitcnt;
    logic [5:0] len;
    logic [7:0] cmd;
    logic [31:0] shift;
    logic dout;
    logic oe;
    logic rdy;
    logic range_err;
    logic crc_err;
    logic integ_err;
    logic [3:0] chan;
    logic [23:0] result;
    logic integ_d;
    logic [7:0] ref_sum;
  } adst_top_s;

  adst_top_s st_r;
  adst_top_s st_nxt;
  adst_pin_if pins ();

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  adst_sync u_sync
  (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .sclk(sclk),
    .cs_n(cs_n),
    .din(din),
    .pins(pins)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  logic [7:0] status_cur;
  logic [7:0] cmd_full;
  logic rise;
  logic fall;
  logic crc_clr;
  logic rdy_set;
  logic new_res;

  // Live status byte
  // channel field
  assign status_cur = {st_r.rdy, st_r.range_err, st_r.crc_err,
                       st_r.integ_err, st_r.chan};

  always_comb
  begin
    st_nxt = st_r;
    crc_clr = 1'b0;
    rdy_set = 1'b0;
    new_res = 1'b0;
    rise = pins.sclk & ~st_r.sclk_d;
    fall = ~pins.sclk & st_r.sclk_d;
    cmd_full = {st_r.cmd[6:0], pins.din};
    st_nxt.sclk_d = pins.sclk;
    // Serial sequencer; sample on rise, shift out on fall
    case (st_r.phase)
      adst_pkg::PH_IDLE:
      begin
        st_nxt.phase = adst_pkg::PH_CMD;
        st_nxt.bitcnt = 6'h00;
      end
      adst_pkg::PH_CMD:
      begin
        if (rise)
        begin
          st_nxt.cmd = cmd_full;
          st_nxt.bitcnt = st_r.bitcnt + 6'h01;
          if (st_r.bitcnt == adst_pkg::CMD_BITS - 6'h01)
          begin
            st_nxt.bitcnt = 6'h00;
            st_nxt.phase = adst_pkg::PH_SKIP;
            if (!cmd_full[adst_pkg::CMD_WEN_BIT] &&
                cmd_full[adst_pkg::CMD_RW_BIT] == adst_pkg::CMD_RW_READ)
            begin
              if (cmd_full[5:0] == adst_pkg::ADDR_STATUS)
              begin
                st_nxt.phase = adst_pkg::PH_READ;
                st_nxt.shift = {status_cur, 24'h000000};
                st_nxt.len = adst_pkg::LEN_STATUS;
                crc_clr = 1'b1;
              end
              else if (cmd_full[5:0] == adst_pkg::ADDR_DATA)
              begin
                st_nxt.phase = adst_pkg::PH_READ;
                st_nxt.shift = {st_r.result,
                                append_status ? status_cur : 8'h00};
                st_nxt.len = append_status ? adst_pkg::LEN_DATA_ST :
                             adst_pkg::LEN_DATA;
                rdy_set = 1'b1;
              end
            end
          end
        end
      end
      adst_pkg::PH_READ:
      begin
        // First fall keeps the MSB up for the host's first rise
        if (fall && st_r.bitcnt != 6'h00)
          st_nxt.shift = {st_r.shift[30:0], 1'b0};
        if (rise)
        begin
          st_nxt.bitcnt = st_r.bitcnt + 6'h01;
          if (st_r.bitcnt == st_r.len - 6'h01)
          begin
            st_nxt.bitcnt = 6'h00;
            st_nxt.phase = adst_pkg::PH_CMD;
          end
        end
      end
      adst_pkg::PH_SKIP:
        st_nxt.phase = adst_pkg::PH_SKIP;
      default:
        st_nxt.phase = adst_pkg::PH_IDLE;
    endcase
    // Deselect aborts any transfer
    if (pins.cs_n)
      st_nxt.phase = adst_pkg::PH_IDLE;

    // Checksum flag; a failing write beats the read clear
    if (crc_clr)
      st_nxt.crc_err = 1'b0;
    if (wr_crc_fail)
      st_nxt.crc_err = 1'b1;

    // Ready flag; fresh data beats the read set, so none is missed
    if (rdy_set)
      st_nxt.rdy = 1'b1;
    new_res = cal_mode ? cal_wr : res_wr;
    if (new_res)
      st_nxt.rdy = 1'b0;

    // clamp and range flag on write
    if (res_wr && !cal_mode)
    begin
      st_nxt.range_err = res_over | res_under;
      st_nxt.result = res_over ? adst_pkg::CLAMP_OVER :
                      res_under ? adst_pkg::CLAMP_UNDER : res_value;
      st_nxt.chan = res_chan;
    end

    st_nxt.integ_d = integ_en;
    if (integ_en && !st_r.integ_d)
      st_nxt.ref_sum = reg_sum;
    else if (integ_en && reg_sum != st_r.ref_sum)
      st_nxt.integ_err = 1'b1;
    if (!integ_en)
      st_nxt.integ_err = 1'b0;

    // ready on the pin outside reads
    st_nxt.dout = (st_nxt.phase == adst_pkg::PH_READ) ?
                  st_nxt.shift[31] : st_nxt.rdy;
    st_nxt.oe = (st_nxt.phase != adst_pkg::PH_IDLE);
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      st_r <= '0;
      st_r.phase <= adst_pkg::PH_IDLE;
      st_r.sclk_d <= 1'b1;
      st_r.rdy <= adst_pkg::STATUS_RST[adst_pkg::ST_RDY_BIT];
      st_r.range_err <= adst_pkg::STATUS_RST[adst_pkg::ST_RANGE_BIT];
      st_r.crc_err <= adst_pkg::STATUS_RST[adst_pkg::ST_CRC_BIT];
      st_r.integ_err <= adst_pkg::STATUS_RST[adst_pkg::ST_INTEG_BIT];
      st_r.chan <= adst_pkg::CHAN_RST;
      st_r.dout <= adst_pkg::STATUS_RST[adst_pkg::ST_RDY_BIT];
    end
    else
      st_r <= st_nxt;
  end

  // Outputs straight from flip-flops
  assign dout_rdy = st_r.dout;
  assign dout_oe = st_r.oe;
  assign status_out = status_cur;
endmodule

// File: hw/adst_pkg.sv
package adst_pkg;
  // Register address codes
  localparam logic [5:0] ADDR_STATUS = 6'h00;
  localparam logic [5:0] ADDR_DATA = 6'h04;
  // Command byte fields
  localparam int CMD_WEN_BIT = 7;
  localparam int CMD_RW_BIT = 6;
  localparam logic CMD_RW_READ = 1'h1;
  // Status register layout and reset
  localparam logic [7:0] STATUS_RST = 8'h80;
  localparam int ST_RDY_BIT = 7;
  localparam int ST_RANGE_BIT = 6;
  localparam int ST_CRC_BIT = 5;
  localparam int ST_INTEG_BIT = 4;
  localparam logic [3:0] CHAN_RST = 4'h0;
  // Result clamp values, as printed
  localparam logic [23:0] CLAMP_OVER = 24'h0FFFFF;
  localparam logic [23:0] CLAMP_UNDER = 24'h000000;
  // Transfer lengths in serial clocks
  localparam logic [5:0] CMD_BITS = 6'h08;
  localparam logic [5:0] LEN_STATUS = 6'h08;
  localparam logic [5:0] LEN_DATA = 6'h18;
  localparam logic [5:0] LEN_DATA_ST = 6'h20;
  // Synchroniser reset for {sclk, cs_n, din}: idle bus
  localparam logic [2:0] PIN_IDLE = 3'h6;

  typedef enum logic [1:0]
  {
    PH_IDLE = 2'b00,
    PH_CMD = 2'b01,
    PH_READ = 2'b10,
    PH_SKIP = 2'b11
  } adst_phase_e;
endpackage

// File: hw/adst_pin_if.sv
`timescale 1ns/1ps
interface adst_pin_if;
  logic sclk;
  logic cs_n;
  logic din;
  modport src (output sclk, output cs_n, output din);
  modport dst (input sclk, input cs_n, input din);
endinterface

// File: hw/adst_sync.sv
`timescale 1ns/1ps
module adst_sync
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Raw serial pins
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  // Synchronised pins
  adst_pin_if.src pins
);
  typedef struct packed
  {
    logic [2:0] s1;
    logic [2:0] s2;
  } adst_sync_s;

  adst_sync_s st_r;
  adst_sync_s st_nxt;

  // Two stages; only the second is seen by logic
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.s1 = {sclk, cs_n, din};
    st_nxt.s2 = st_r.s1;
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      st_r <= {adst_pkg::PIN_IDLE, adst_pkg::PIN_IDLE};
    else
      st_r <= st_nxt;
  end

  assign pins.sclk = st_r.s2[2];
  assign pins.cs_n = st_r.s2[1];
  assign pins.din = st_r.s2[0];
endmodule

// File: verif/adst_checker.sv
`timescale 1ns/1ps
module adst_checker
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Engine and mode inputs
  input wire logic res_wr,
  input wire logic res_over,
  input wire logic res_under,
  input wire logic [3:0] res_chan,
  input wire logic cal_mode,
  input wire logic cal_wr,
  input wire logic integ_en,
  input wire logic wr_crc_fail,
  // Serial pins
  input wire logic cs_n,
  input wire logic dout_oe,
  // Status byte
  input wire logic [7:0] status_out
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);
  // Result write counts only outside calibration
  wire logic upd = res_wr && !cal_mode;
  AST_RESET: assert property
    ($past(sys_rst) |-> status_out == 8'h80) else $error("reset value");
  AST_RDY_CLR: assert property
    (upd |=> !status_out[7]) else $error("ready not cleared");
  AST_CAL_CLR: assert property
    (cal_mode && cal_wr |=> !status_out[7]) else $error("cal ready");
  AST_RANGE: assert property
    (upd |=> status_out[6] == $past(res_over || res_under))
    else $error("range flag");
  AST_RANGE_HOLD: assert property
    (!upd |=> $stable(status_out[6])) else $error("range moved");
  AST_CRC_SET: assert property
    (wr_crc_fail |=> status_out[5]) else $error("checksum flag");
  AST_CHAN: assert property
    (upd |=> status_out[3:0] == $past(res_chan)) else $error("channel");
  AST_INTEG_CLR: assert property
    (!integ_en |=> !status_out[4]) else $error("integrity clear");
  // Output enable follows the two-stage synced select
  AST_OE_ON: assert property
    (!cs_n [*3] |=> dout_oe) else $error("pin not driven");
  AST_OE_OFF: assert property
    (cs_n [*3] |=> !dout_oe) else $error("pin not released");
  // Main scenarios reached
  cover property (upd && res_over);
  cover property (wr_crc_fail);
  cover property (integ_en && status_out[4]);
endmodule

// File: verif/adst_host.sv
`timescale 1ns/1ps
module adst_host
(
  // Serial pins
  output logic sclk,
  output logic cs_n,
  output logic din,
  input wire logic dout_rdy
);
  // Mode 3 bus idles with clock high, deselected
  initial
  begin
    sclk = 1'h1;
    cs_n = 1'h1;
    din = 1'h0;
  end
  ////////////////////////////////////////////////////////////
  // One frame; sample at each rise, while the bit still stands
  // read checksums stay with the host; none appended here
  task automatic xfer(input logic [7:0] cmd, input int n,
    output logic [31:0] rx, output logic idle);
    cs_n = 1'h0;
    #80 rx = 32'h0;
    for (int i = 7; i >= 0; i--)
    begin
      sclk = 1'h0;
      din = cmd[i];
      #80 sclk = 1'h1;
      #80;
    end
    for (int i = 0; i < n; i++)
    begin
      sclk = 1'h0;
      #80 rx = {rx[30:0], dout_rdy};
      sclk = 1'h1;
      #80;
    end
    #240 idle = dout_rdy;
    cs_n = 1'h1;
    // Released line flips so a stale level cannot pass
    din = ~din;
    #160;
  endtask
endmodule

// File: verif/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic ref_clk = 1'h0, sys_rst = 1'h1, sclk, cs_n, din, dout_rdy, dout_oe;
  logic res_wr = 1'h0, res_over = 1'h0, res_under = 1'h0, cal_mode = 1'h0;
  logic cal_wr = 1'h0, append_status = 1'h0, integ_en = 1'h0, idle;
  logic wr_crc_fail = 1'h0;
  logic [23:0] res_value = 24'h0;
  logic [3:0] res_chan = 4'h0;
  logic [7:0] reg_sum = 8'h00, status_out;
  logic [31:0] rx;
  int n_errors = 0, cmp_count = 0;
  // 50 MHz clock
  always #10 ref_clk = ~ref_clk;
  adst_top i_dut (.ref_clk, .sys_rst, .sclk, .cs_n, .din, .dout_rdy,
    .dout_oe, .res_wr, .res_value, .res_over, .res_under, .res_chan,
    .cal_mode, .cal_wr, .append_status, .integ_en, .reg_sum,
    .wr_crc_fail, .status_out);
  adst_host i_host (.sclk, .cs_n, .din, .dout_rdy);
  ////////////////////////////////////////////////////////////
  // Compare and count
  task automatic chk(input logic [31:0] seen, exp, input string nm);
    cmp_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Verdict
  task automatic results();
    if (n_errors == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Host frame, launched off the falling edge, away from the sampling edge
  task automatic rd(input logic [7:0] cmd, input int n, input logic app);
    @(negedge ref_clk) append_status = app;
    i_host.xfer(cmd, n, rx, idle);
  endtask
  // Single-cycle engine write
  task automatic put(input logic [3:0] c, input logic o, u,
    input logic [23:0] v);
    @(negedge ref_clk);
    {res_chan, res_over, res_under, res_value, res_wr} = {c, o, u, v, 1'h1};
    @(negedge ref_clk) res_wr = 1'h0;
    @(negedge ref_clk);
  endtask
  // Sequence
  initial
  begin
    repeat (16) @(negedge ref_clk);
    sys_rst = 1'h0;
    repeat (3) @(negedge ref_clk);
    chk(status_out, 8'h80, "reset status");
    chk({dout_rdy, dout_oe}, 2'h2, "reset pins");
    rd(8'h40, 8, 1'h0);
    chk(rx, 8'h80, "status read");
    chk(status_out[5], 1'h0, "no read checksum flag");
    put(4'h5, 1'h1, 1'h0, 24'hABCDEF);
    chk(status_out, 8'h45, "overrange");
    rd(8'h44, 32, 1'h1);
    chk(rx, 32'h0FFFFF45, "data and status");
    chk(status_out[7], 1'h1, "ready after read");
    chk(idle, 1'h1, "idle pin");
    put(4'hF, 1'h0, 1'h1, 24'h123456);
    chk(status_out, 8'h4F, "underrange");
    rd(8'h40, 8, 1'h0);
    chk(rx, 8'h4F, "status after underrange");
    chk(idle, 1'h0, "idle pin low");
    rd(8'h44, 24, 1'h0);
    chk(rx, 32'h0, "underrange clamp");
    put(4'h0, 1'h0, 1'h0, 24'h5A5A5A);
    chk(status_out, 8'h00, "range cleared");
    rd(8'h44, 24, 1'h0);
    chk(rx, 32'h5A5A5A, "plain data");
    rd(8'h00, 8, 1'h0);
    chk(status_out, 8'h80, "status write");
    @(negedge ref_clk) wr_crc_fail = 1'h1;
    @(negedge ref_clk) wr_crc_fail = 1'h0;
    rd(8'h40, 8, 1'h0);
    chk(rx, 8'hA0, "checksum flag");
    chk(status_out, 8'h80, "checksum cleared");
    @(negedge ref_clk) {integ_en, reg_sum} = {1'h1, 8'h3C};
    repeat (3) @(negedge ref_clk);
    chk(status_out, 8'h80, "integrity ref");
    reg_sum = 8'h3D;
    rd(8'h40, 8, 1'h0);
    chk(status_out, 8'h90, "integrity kept");
    @(negedge ref_clk) integ_en = 1'h0;
    repeat (2) @(negedge ref_clk);
    chk(status_out, 8'h80, "integrity cleared");
    cal_mode = 1'h1;
    put(4'h3, 1'h0, 1'h0, 24'h1);
    chk(status_out, 8'h80, "cal ignores result");
    cal_wr = 1'h1;
    @(negedge ref_clk) {cal_mode, cal_wr} = 2'h0;
    chk(status_out[7], 1'h0, "cal ready");
    for (int c = 0; c < 16; c++)
    begin
      put(c[3:0], 1'h0, 1'h0, 24'h0);
      chk(status_out[3:0], c[3:0], "channel");
    end
    results();
  end
endmodule
bind adst_top adst_checker i_chk (.ref_clk, .sys_rst, .res_wr, .res_over,
  .res_under, .res_chan, .cal_mode, .cal_wr, .integ_en, .wr_crc_fail,
  .status_out, .cs_n, .dout_oe);
